// ===== core/dfbc_cycle.sv
// one multiplexed-address bus cycle on the flash pins
`default_nettype none
`include "dfbc_params.svh"
module dfbc_cycle #(
  parameter int AW = 20,
  parameter int DW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic is_write,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic done,
  output logic [DW-1:0] rdata,
  output logic [AW/2-1:0] mux_addr_in,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic out_en_n,
  output logic wr_en_n,
  output logic [DW-1:0] data_bus_wr,
  output logic data_bus_oe,
  input wire logic [DW-1:0] data_bus_rd
);
  localparam int HW = AW / 2;

  initial
  begin
    if (AW % 2 != 0 || DW < 8)
      $error("dfbc_cycle: address width must be even, data width >= 8");
  end

  dfbc_pkg::dfbc_cyc_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic done_r, done_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic [HW-1:0] maddr_r, maddr_nxt;
  logic ras_r, ras_nxt, cas_r, cas_nxt, oe_r, oe_nxt, we_r, we_nxt;
  logic [DW-1:0] dout_r, dout_nxt;
  logic doe_r, doe_nxt;
  logic [DW-1:0] ds1_r, ds2_r, ds3_r;

  // only the second flop reads the first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ds1_r <= '0;
      ds2_r <= '0;
      ds3_r <= '0;
    end
    else
    begin
      ds1_r <= data_bus_rd;
      ds2_r <= ds1_r;
      ds3_r <= ds2_r;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    maddr_nxt = maddr_r;
    ras_nxt = ras_r;
    cas_nxt = cas_r;
    oe_nxt = oe_r;
    we_nxt = we_r;
    dout_nxt = dout_r;
    doe_nxt = doe_r;
    unique case (state_r)
      dfbc_pkg::DFBC_CYC_IDLE:
      begin
        if (start)
        begin
          wr_nxt = is_write;
          maddr_nxt = addr[AW-1:HW];
          dout_nxt = wdata;
          cnt_nxt = 8'(`DFBC_CYC_ADDR_SETUP);
          state_nxt = dfbc_pkg::DFBC_CYC_ROW_SETUP;
        end
      end
      dfbc_pkg::DFBC_CYC_ROW_SETUP:
      begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          ras_nxt = 1'b0;
          cnt_nxt = 8'(`DFBC_CYC_ROW_TO_COL);
          state_nxt = dfbc_pkg::DFBC_CYC_ROW_LATCH;
        end
      end
      dfbc_pkg::DFBC_CYC_ROW_LATCH:
      begin
        // column half goes out only after the row strobe fell
        maddr_nxt = addr[HW-1:0];
        doe_nxt = wr_r;
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          cas_nxt = 1'b0;
          oe_nxt = wr_r;
          we_nxt = ~wr_r;
          cnt_nxt = 8'(`DFBC_CYC_ACCESS);
          state_nxt = dfbc_pkg::DFBC_CYC_COL_LATCH;
        end
      end
      dfbc_pkg::DFBC_CYC_COL_LATCH:
      begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          cnt_nxt = 8'(`DFBC_CYC_SYNC);
          state_nxt = dfbc_pkg::DFBC_CYC_CAPTURE;
        end
      end
      dfbc_pkg::DFBC_CYC_CAPTURE:
      begin
        // read data passes three flops; wait till the last two agree
        if (cnt_r != 8'h00)
          cnt_nxt = cnt_r - 8'h01;
        else if (wr_r || ds2_r == ds3_r)
        begin
          if (!wr_r)
            rdata_nxt = ds3_r;
          ras_nxt = 1'b1;
          cas_nxt = 1'b1;
          oe_nxt = 1'b1;
          we_nxt = 1'b1;
          doe_nxt = 1'b0;
          cnt_nxt = 8'(`DFBC_CYC_PRECHARGE);
          state_nxt = dfbc_pkg::DFBC_CYC_PRECHARGE;
        end
      end
      dfbc_pkg::DFBC_CYC_PRECHARGE:
      begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          done_nxt = 1'b1;
          state_nxt = dfbc_pkg::DFBC_CYC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= dfbc_pkg::DFBC_CYC_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= '0;
      maddr_r <= '0;
      ras_r <= 1'b1;
      cas_r <= 1'b1;
      oe_r <= 1'b1;
      we_r <= 1'b1;
      dout_r <= '0;
      doe_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      maddr_r <= maddr_nxt;
      ras_r <= ras_nxt;
      cas_r <= cas_nxt;
      oe_r <= oe_nxt;
      we_r <= we_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
    end
  end

  assign done = done_r;
  assign rdata = rdata_r;
  assign mux_addr_in = maddr_r;
  assign row_strobe_n = ras_r;
  assign col_strobe_n = cas_r;
  assign out_en_n = oe_r;
  assign wr_en_n = we_r;
  assign data_bus_wr = dout_r;
  assign data_bus_oe = doe_r;
endmodule
`default_nettype wire

// ===== core/dfbc_host.sv
// ahb-lite controlled host that drives the dram-style flash pins
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`default_nettype none
`include "dfbc_params.svh"
module dfbc_host #(
  parameter int AW = 20,
  parameter int DW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [AW/2-1:0] mux_addr_in,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic out_en_n,
  output logic wr_en_n,
  output logic powerdown_reset_n,
  output logic [DW-1:0] data_bus_wr,
  output logic data_bus_oe,
  input wire logic [DW-1:0] data_bus_rd,
  input wire logic done_flag_n_od
);
  initial
  begin
    if (AW != 20 || DW != 16)
      $error("dfbc_host: register map serves 20-bit address, 16-bit data");
  end

  // ahb slave: reads take one wait state so hrdata sees committed writes
  logic dph_wr_r, dph_wr_nxt;
  logic [7:0] dph_ofs_r, dph_ofs_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic hreadyout_r, hreadyout_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic hresp_r;

  // software registers
  dfbc_pkg::dfbc_op_t op_r, op_nxt;
  logic pdown_r, pdown_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] wdata_r, wdata_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic refused_r, refused_nxt, done_st_r, done_st_nxt;
  logic pdn_pin_r, pdn_pin_nxt;

  // sequencer
  dfbc_pkg::dfbc_seq_state_t seq_r, seq_nxt;
  logic cyc_start_r, cyc_start_nxt;
  logic cyc_wr_r, cyc_wr_nxt;
  logic [AW-1:0] cyc_addr_r, cyc_addr_nxt;
  logic [DW-1:0] cyc_data_r, cyc_data_nxt;
  logic two_r, two_nxt;
  logic [AW-1:0] nd_addr_r, nd_addr_nxt;
  logic [DW-1:0] nd_data_r, nd_data_nxt;
  logic nd_wr_r, nd_wr_nxt;

  // ready/busy pin: three flops, a change counts when the last two agree
  logic rdy_s1_r, rdy_s2_r, rdy_s3_r, dev_ready_r, dev_ready_nxt;

  logic cyc_done;
  logic [DW-1:0] cyc_rdata;
  logic go_wr;
  logic wr_now;
  logic [31:0] wval;
  dfbc_pkg::dfbc_op_t go_op;

  assign wr_now = dph_wr_r;
  assign wval = hwdata;
  assign go_wr = wr_now && dph_ofs_r == `DFBC_OFS_CTRL &&
                 wval[`DFBC_CTRL_GO];
  assign go_op = dfbc_pkg::dfbc_op_t'(wval[`DFBC_CTRL_OP_MSB:
                                           `DFBC_CTRL_OP_LSB]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdy_s1_r <= 1'b1;
      rdy_s2_r <= 1'b1;
      rdy_s3_r <= 1'b1;
    end
    else
    begin
      rdy_s1_r <= done_flag_n_od;
      rdy_s2_r <= rdy_s1_r;
      rdy_s3_r <= rdy_s2_r;
    end
  end

  always_comb
  begin
    // the pin is open-drain: high means released, i.e. ready
    dev_ready_nxt = (rdy_s2_r == rdy_s3_r) ? rdy_s3_r :
                    dev_ready_r;
  end

  // bus slave and register file
  always_comb
  begin
    dph_wr_nxt = 1'b0;
    dph_ofs_nxt = dph_ofs_r;
    rd_pend_nxt = 1'b0;
    hreadyout_nxt = 1'b1;
    hrdata_nxt = hrdata_r;
    op_nxt = op_r;
    pdown_nxt = pdown_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    refused_nxt = refused_r;
    done_st_nxt = done_st_r;
    if (hsel && htrans[1] && hready)
    begin
      dph_ofs_nxt = haddr[7:0];
      dph_wr_nxt = hwrite;
      if (!hwrite)
      begin
        rd_pend_nxt = 1'b1;
        hreadyout_nxt = 1'b0;
      end
    end
    if (rd_pend_r)
    begin
      unique case (dph_ofs_r)
        `DFBC_OFS_CTRL:
          hrdata_nxt = {27'h000_0000, pdown_r, op_r, 1'b0};
        `DFBC_OFS_ADDR:
          hrdata_nxt = {12'h000, addr_r};
        `DFBC_OFS_WDATA:
          hrdata_nxt = {16'h0000, wdata_r};
        `DFBC_OFS_RDATA:
          hrdata_nxt = {16'h0000, rdata_r};
        `DFBC_OFS_STATUS:
          hrdata_nxt = {28'h000_0000, done_st_r, refused_r, dev_ready_r,
                        seq_r != dfbc_pkg::DFBC_SEQ_IDLE};
        default:
          hrdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_now)
    begin
      unique case (dph_ofs_r)
        `DFBC_OFS_CTRL:
        begin
          op_nxt = go_op;
          pdown_nxt = wval[`DFBC_CTRL_PDOWN];
        end
        `DFBC_OFS_ADDR:
          addr_nxt = wval[AW-1:0];
        `DFBC_OFS_WDATA:
          wdata_nxt = wval[DW-1:0];
        `DFBC_OFS_STATUS:
        begin
          if (wval[`DFBC_ST_REFUSED])
            refused_nxt = 1'b0;
          if (wval[`DFBC_ST_DONE])
            done_st_nxt = 1'b0;
        end
        default:
          ;
      endcase
    end
    if (cyc_done && !cyc_wr_r)
      rdata_nxt = cyc_rdata;
    // hardware set wins over a same-cycle clear
    if (cyc_done && seq_r == dfbc_pkg::DFBC_SEQ_SECOND ||
        cyc_done && seq_r == dfbc_pkg::DFBC_SEQ_FIRST && !two_r)
      done_st_nxt = 1'b1;
    if (go_wr && (seq_r != dfbc_pkg::DFBC_SEQ_IDLE || pdown_r ||
        wval[`DFBC_CTRL_PDOWN]))
      refused_nxt = 1'b1;
    if (go_wr && !dev_ready_r && (go_op == dfbc_pkg::DFBC_OP_PROGRAM ||
        go_op == dfbc_pkg::DFBC_OP_ERASE))
      refused_nxt = 1'b1;
  end

  // sequencer: one or two pin cycles per order
  always_comb
  begin
    seq_nxt = seq_r;
    cyc_start_nxt = 1'b0;
    cyc_wr_nxt = cyc_wr_r;
    cyc_addr_nxt = cyc_addr_r;
    cyc_data_nxt = cyc_data_r;
    two_nxt = two_r;
    nd_addr_nxt = nd_addr_r;
    nd_data_nxt = nd_data_r;
    nd_wr_nxt = nd_wr_r;
    pdn_pin_nxt = ~pdown_r;
    unique case (seq_r)
      dfbc_pkg::DFBC_SEQ_IDLE:
      begin
        if (go_wr && !pdown_r && !wval[`DFBC_CTRL_PDOWN] &&
            !(!dev_ready_r && (go_op == dfbc_pkg::DFBC_OP_PROGRAM ||
              go_op == dfbc_pkg::DFBC_OP_ERASE)))
        begin
          cyc_start_nxt = 1'b1;
          cyc_wr_nxt = 1'b1;
          cyc_addr_nxt = addr_r;
          two_nxt = 1'b0;
          nd_addr_nxt = addr_r;
          nd_data_nxt = wdata_r;
          nd_wr_nxt = 1'b1;
          // upper byte of a command write is always zero
          unique case (go_op)
            dfbc_pkg::DFBC_OP_READ:
              cyc_wr_nxt = 1'b0;
            dfbc_pkg::DFBC_OP_WRITE:
              cyc_data_nxt = wdata_r;
            dfbc_pkg::DFBC_OP_CMD:
              cyc_data_nxt = {8'h00,
                              wdata_r[7:0]};
            dfbc_pkg::DFBC_OP_ID_READ:
            begin
              cyc_data_nxt = {8'h00, `DFBC_CMD_READ_ID};
              nd_addr_nxt = {19'h0_0000, addr_r[0]};
              nd_wr_nxt = 1'b0;
              two_nxt = 1'b1;
            end
            dfbc_pkg::DFBC_OP_PROGRAM:
            begin
              cyc_data_nxt = {8'h00, `DFBC_CMD_PROGRAM};
              two_nxt = 1'b1;
            end
            dfbc_pkg::DFBC_OP_ERASE:
            begin
              cyc_data_nxt = {8'h00, `DFBC_CMD_ERASE};
              nd_addr_nxt = addr_r & `DFBC_BLOCK_MASK;
              nd_data_nxt = {8'h00, `DFBC_CMD_CONFIRM};
              two_nxt = 1'b1;
            end
            dfbc_pkg::DFBC_OP_SUSPEND:
              cyc_data_nxt = {8'h00, `DFBC_CMD_SUSPEND};
            dfbc_pkg::DFBC_OP_RESUME:
              cyc_data_nxt = {8'h00, `DFBC_CMD_CONFIRM};
          endcase
          seq_nxt = dfbc_pkg::DFBC_SEQ_FIRST;
        end
      end
      dfbc_pkg::DFBC_SEQ_FIRST:
      begin
        if (cyc_done)
        begin
          if (two_r)
          begin
            cyc_start_nxt = 1'b1;
            cyc_wr_nxt = nd_wr_r;
            cyc_addr_nxt = nd_addr_r;
            cyc_data_nxt = nd_data_r;
            seq_nxt = dfbc_pkg::DFBC_SEQ_SECOND;
          end
          else
            seq_nxt = dfbc_pkg::DFBC_SEQ_IDLE;
        end
      end
      dfbc_pkg::DFBC_SEQ_SECOND:
      begin
        if (cyc_done)
          seq_nxt = dfbc_pkg::DFBC_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_r <= 1'b0;
      dph_ofs_r <= 8'h00;
      rd_pend_r <= 1'b0;
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h0000_0000;
      hresp_r <= 1'b0;
      op_r <= dfbc_pkg::DFBC_OP_READ;
      pdown_r <= 1'b0;
      addr_r <= `DFBC_RST_ADDR;
      wdata_r <= `DFBC_RST_WDATA;
      rdata_r <= 16'h0000;
      refused_r <= 1'b0;
      done_st_r <= 1'b0;
      pdn_pin_r <= 1'b1;
      dev_ready_r <= 1'b1;
      seq_r <= dfbc_pkg::DFBC_SEQ_IDLE;
      cyc_start_r <= 1'b0;
      cyc_wr_r <= 1'b0;
      cyc_addr_r <= 20'h0_0000;
      cyc_data_r <= 16'h0000;
      two_r <= 1'b0;
      nd_addr_r <= 20'h0_0000;
      nd_data_r <= 16'h0000;
      nd_wr_r <= 1'b0;
    end
    else
    begin
      dph_wr_r <= dph_wr_nxt;
      dph_ofs_r <= dph_ofs_nxt;
      rd_pend_r <= rd_pend_nxt;
      hreadyout_r <= hreadyout_nxt;
      hrdata_r <= hrdata_nxt;
      hresp_r <= 1'b0;
      op_r <= op_nxt;
      pdown_r <= pdown_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      refused_r <= refused_nxt;
      done_st_r <= done_st_nxt;
      pdn_pin_r <= pdn_pin_nxt;
      dev_ready_r <= dev_ready_nxt;
      seq_r <= seq_nxt;
      cyc_start_r <= cyc_start_nxt;
      cyc_wr_r <= cyc_wr_nxt;
      cyc_addr_r <= cyc_addr_nxt;
      cyc_data_r <= cyc_data_nxt;
      two_r <= two_nxt;
      nd_addr_r <= nd_addr_nxt;
      nd_data_r <= nd_data_nxt;
      nd_wr_r <= nd_wr_nxt;
    end
  end

  dfbc_cycle #(
    .AW(AW),
    .DW(DW)
  ) u_cycle (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(cyc_start_r),
    .is_write(cyc_wr_r),
    .addr(cyc_addr_r),
    .wdata(cyc_data_r),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .mux_addr_in(mux_addr_in),
    .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n),
    .out_en_n(out_en_n),
    .wr_en_n(wr_en_n),
    .data_bus_wr(data_bus_wr),
    .data_bus_oe(data_bus_oe),
    .data_bus_rd(data_bus_rd)
  );

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign powerdown_reset_n = pdn_pin_r;
endmodule
`default_nettype wire

// ===== core/dfbc_params.svh
// constants for the flash bus command controller
`ifndef DFBC_PARAMS_SVH
`define DFBC_PARAMS_SVH

// register byte offsets on the ahb-lite port
`define DFBC_OFS_CTRL 8'h00
`define DFBC_OFS_ADDR 8'h04
`define DFBC_OFS_WDATA 8'h08
`define DFBC_OFS_RDATA 8'h0C
`define DFBC_OFS_STATUS 8'h10

// ctrl fields
`define DFBC_CTRL_GO 0
`define DFBC_CTRL_OP_LSB 1
`define DFBC_CTRL_OP_MSB 3
`define DFBC_CTRL_PDOWN 4

// status fields
`define DFBC_ST_ACTIVE 0
`define DFBC_ST_DEV_READY 1
`define DFBC_ST_REFUSED 2
`define DFBC_ST_DONE 3

// command codes, low byte only
`define DFBC_CMD_READ_ARRAY 8'hFF
`define DFBC_CMD_READ_ID 8'h90
`define DFBC_CMD_READ_STATUS 8'h70
`define DFBC_CMD_CLEAR_STATUS 8'h50
`define DFBC_CMD_PROGRAM 8'h40
`define DFBC_CMD_PROGRAM_ALT 8'h10
`define DFBC_CMD_ERASE 8'h20
`define DFBC_CMD_CONFIRM 8'hD0
`define DFBC_CMD_SUSPEND 8'hB0

// 32 blocks of 32 kwords: block bits are address 19..15
`define DFBC_BLOCK_MASK 20'hF_8000

// reset values
`define DFBC_RST_ADDR 20'h0_0000
`define DFBC_RST_WDATA 16'h0000

// pin timing, nanoseconds, and the clock period in picoseconds
`define DFBC_CLK_PERIOD_PS 5000
`define DFBC_T_ADDR_SETUP_NS 10
`define DFBC_T_ROW_TO_COL_NS 20
`define DFBC_T_ACCESS_NS 100
`define DFBC_T_PRECHARGE_NS 50
`define DFBC_NS_TO_CYC(ns) (((ns) * 1000 + `DFBC_CLK_PERIOD_PS - 1) / \
  `DFBC_CLK_PERIOD_PS)
`define DFBC_CYC_ADDR_SETUP `DFBC_NS_TO_CYC(`DFBC_T_ADDR_SETUP_NS)
`define DFBC_CYC_ROW_TO_COL `DFBC_NS_TO_CYC(`DFBC_T_ROW_TO_COL_NS)
`define DFBC_CYC_ACCESS `DFBC_NS_TO_CYC(`DFBC_T_ACCESS_NS)
`define DFBC_CYC_PRECHARGE `DFBC_NS_TO_CYC(`DFBC_T_PRECHARGE_NS)
`define DFBC_CYC_SYNC 3

`endif

// ===== core/dfbc_pkg.sv
// types shared by the flash bus command controller
`default_nettype none
package dfbc_pkg;
  typedef enum logic [2:0] {
    DFBC_OP_READ,
    DFBC_OP_WRITE,
    DFBC_OP_CMD,
    DFBC_OP_ID_READ,
    DFBC_OP_PROGRAM,
    DFBC_OP_ERASE,
    DFBC_OP_SUSPEND,
    DFBC_OP_RESUME
  } dfbc_op_t;

  typedef enum {
    DFBC_CYC_IDLE,
    DFBC_CYC_ROW_SETUP,
    DFBC_CYC_ROW_LATCH,
    DFBC_CYC_COL_LATCH,
    DFBC_CYC_CAPTURE,
    DFBC_CYC_PRECHARGE
  } dfbc_cyc_state_t;

  typedef enum {
    DFBC_SEQ_IDLE,
    DFBC_SEQ_FIRST,
    DFBC_SEQ_SECOND
  } dfbc_seq_state_t;
endpackage
`default_nettype wire

// ===== verification/dfbc_flash_model.sv
// behavioural flash device on the multiplexed-address pins
`default_nettype none
module dfbc_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h1357, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h2468 // arbitrary value
) (
  input wire logic [9:0] mux_addr_in,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  input wire logic powerdown_reset_n,
  input wire logic [15:0] data_bus,
  input wire logic vpp_ok,
  output logic [15:0] dev_q,
  output logic dev_oe,
  output logic busy_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [19:0] a;
  logic [1:0] mode;
  logic [1:0] pend;
  logic [2:0] st;
  logic susp;
  logic [31:0] erased = 32'h0000_0000;
  int left;
  logic [15:0] mem [logic [19:0]];
  wire logic busy = left > 0 && !susp;
  assign busy_pull = busy && powerdown_reset_n;
  assign dev_oe = powerdown_reset_n && !row_strobe_n && !col_strobe_n
    && !out_en_n && wr_en_n;
  always #5 if (busy) left = left - 1;
  initial clr();
  always @(negedge powerdown_reset_n) clr();
  always @(negedge row_strobe_n) a[19:10] = mux_addr_in;
  always @(negedge col_strobe_n)
  begin
    a[9:0] = mux_addr_in;
    #1;
    dev_q = rd();
    if (powerdown_reset_n && !wr_en_n) take(data_bus);
  end
  task automatic clr();
    mode = 2'd0;
    pend = 2'd0;
    left = 0;
    susp = 1'b0;
    st = 3'b000;
  endtask
  function automatic logic [15:0] rd();
    if (mode == 2'd1)
      return a[19:1] == 0 ? (a[0] ? PART_CODE : MAKER_CODE) : ~MAKER_CODE;
    if (mode == 2'd2)
      return {8'h00, !busy, susp, st, 3'b000};
    if (mem.exists(a))
      return mem[a];
    return erased[a[19:15]] ? 16'hFFFF : a[15:0] ^ 16'h5A5A;
  endfunction
  task automatic take(input logic [15:0] d);
    logic [1:0] p;
    p = pend;
    pend = 2'd0;
    if (p != 2'd0)
      mode = 2'd2;
    if (p == 2'd1)
    begin
      if (vpp_ok) mem[a] = d;
      else st[1:0] = 2'b11;
      left = vpp_ok ? 300 : 2;
    end
    else if (p == 2'd2)
    begin
      if (d[7:0] == 8'hD0 && vpp_ok) erased[a[19:15]] = 1'b1;
      left = 800;
    end
    else
      case (d[7:0])
        8'hFF: mode = 2'd0;
        8'h90: mode = 2'd1;
        8'h70: mode = 2'd2;
        8'h50: st = 3'b000;
        8'h40, 8'h10: pend = busy ? 2'd0 : 2'd1;
        8'h20: pend = busy ? 2'd0 : 2'd2;
        8'hB0: susp = left > 0;
        8'hD0: susp = 1'b0;
        default: ;
      endcase
  endtask
endmodule
`default_nettype wire

// ===== verification/dfbc_host_asserts.sv
// pin-level checks for the flash bus command controller
`default_nettype none
module dfbc_host_asserts #(
  parameter int AW = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [AW/2-1:0] mux_addr_in,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  input wire logic powerdown_reset_n,
  input wire logic data_bus_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  row_first_a:
    assert property ($fell(col_strobe_n) |-> !row_strobe_n)
    else $error("column strobe before row strobe");
  row_setup_a:
    assert property ($fell(row_strobe_n) |-> $stable(mux_addr_in))
    else $error("row address moved at row strobe");
  col_hold_a:
    assert property ($fell(col_strobe_n) |=> $stable(mux_addr_in) [*8])
    else $error("column address moved during access");
  col_width_a:
    assert property ($fell(col_strobe_n) |-> !col_strobe_n [*8])
    else $error("column strobe too short");
  read_float_a:
    assert property (!out_en_n |-> !data_bus_oe && wr_en_n && !col_strobe_n)
    else $error("host drives bus during read");
  write_drive_a:
    assert property (!wr_en_n |->
      data_bus_oe && !col_strobe_n && !row_strobe_n)
    else $error("write without strobes or data");
  standby_end_a:
    assert property ($rose(row_strobe_n) |->
      col_strobe_n && out_en_n && wr_en_n)
    else $error("row released before column");
  pdown_quiet_a:
    assert property (!powerdown_reset_n |-> row_strobe_n && !data_bus_oe)
    else $error("pin activity in power-down");
  read_wait_a:
    assert property (hsel && htrans[1] && !hwrite && hready |=>
      !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  resp_okay_a:
    assert property (hresp == 1'b0)
    else $error("error response");
endmodule
bind dfbc_host dfbc_host_asserts #(.AW(AW)) dfbc_host_asserts_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .mux_addr_in(mux_addr_in), .row_strobe_n(row_strobe_n),
  .col_strobe_n(col_strobe_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
  .powerdown_reset_n(powerdown_reset_n), .data_bus_oe(data_bus_oe));
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench: ahb-lite orders to the host, flash model beyond
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hwrite, vpp_ok, hreadyout, hresp, rs_n, cs_n;
  logic oe_n, we_n, pd_n, dboe, dev_oe, busy_pull;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [9:0] mux;
  logic [15:0] dbw, dev_q;
  int fails, check_count;
  // released bus shows a pattern that moves every half cycle
  wire logic [15:0] dbr = dboe ? dbw : dev_oe ? dev_q : {16{hclk}} ^ 16'hA5A5;
  dfbc_host dfbc_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .mux_addr_in(mux), .row_strobe_n(rs_n),
    .col_strobe_n(cs_n), .out_en_n(oe_n), .wr_en_n(we_n),
    .powerdown_reset_n(pd_n), .data_bus_wr(dbw), .data_bus_oe(dboe),
    .data_bus_rd(dbr), .done_flag_n_od(!busy_pull));
  dfbc_flash_model dfbc_flash_model_i (.mux_addr_in(mux), .row_strobe_n(rs_n),
    .col_strobe_n(cs_n), .out_en_n(oe_n), .wr_en_n(we_n),
    .powerdown_reset_n(pd_n), .data_bus(dbr), .vpp_ok(vpp_ok),
    .dev_q(dev_q), .dev_oe(dev_oe), .busy_pull(busy_pull));
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = !hclk;
  end
  task automatic results();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // runs one op to completion and leaves the read data in q
  task automatic run(input logic [2:0] op, input logic [19:0] a,
    input logic [15:0] d);
    bus(1'b1, 8'h04, {12'h000, a});
    bus(1'b1, 8'h08, {16'h0000, d});
    bus(1'b1, 8'h00, {28'h000_0000, op, 1'b1});
    repeat (200)
    begin
      bus(1'b0, 8'h10, 32'h0000_0000);
      if (q[3] === 1'b1) break;
    end
    bus(1'b1, 8'h10, 32'h0000_0008);
    bus(1'b0, 8'h0C, 32'h0000_0000);
  endtask
  task automatic rdy();
    repeat (400)
    begin
      bus(1'b0, 8'h10, 32'h0000_0000);
      if (q[1] === 1'b1) break;
    end
    cmp(q & 32'h0000_0002, 32'h0000_0002);
  endtask
  initial
  begin
    #200_000;
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
  initial
  begin
    hresetn = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    vpp_ok = 1'b1;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h10, 32'h0000_0000);
    cmp(q, 32'h0000_0002);
    bus(1'b0, 8'h20, 32'h0000_0000);
    cmp(q, 32'h0000_0000);
    run(3'd0, 20'h1_2345, 16'h0000);
    cmp(q, {16'h0000, 16'h2345 ^ 16'h5A5A});
    run(3'd3, 20'h0_0000, 16'h0000);
    cmp(q, 32'h0000_1357);
    run(3'd3, 20'h3_FF01, 16'h0000);
    cmp(q, 32'h0000_2468);
    run(3'd2, 20'h0_0000, 16'hAAFF);
    run(3'd4, 20'h0_ABCD, 16'hBEEF);
    bus(1'b0, 8'h10, 32'h0000_0000);
    cmp(q & 32'h0000_0002, 32'h0000_0000);
    run(3'd0, 20'h0_0000, 16'h0000);
    cmp(q, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0009);
    bus(1'b0, 8'h10, 32'h0000_0000);
    cmp(q & 32'h0000_0005, 32'h0000_0004);
    bus(1'b1, 8'h10, 32'h0000_0004);
    rdy();
    run(3'd2, 20'h0_0000, 16'h00FF);
    run(3'd0, 20'h0_ABCD, 16'h0000);
    cmp(q, 32'h0000_BEEF);
    run(3'd2, 20'h0_0000, 16'h0010);
    run(3'd1, 20'h0_ABCE, 16'h1357);
    rdy();
    run(3'd2, 20'h0_0000, 16'h00FF);
    run(3'd0, 20'h0_ABCE, 16'h0000);
    cmp(q, 32'h0000_1357);
    run(3'd5, 20'h2_ABCD, 16'h0000);
    run(3'd6, 20'h0_0000, 16'h0000);
    bus(1'b0, 8'h10, 32'h0000_0000);
    cmp(q & 32'h0000_0002, 32'h0000_0002);
    run(3'd0, 20'h0_0000, 16'h0000);
    cmp(q, 32'h0000_00C0);
    run(3'd7, 20'h0_0000, 16'h0000);
    bus(1'b0, 8'h10, 32'h0000_0000);
    cmp(q & 32'h0000_0002, 32'h0000_0000);
    rdy();
    run(3'd2, 20'h0_0000, 16'h00FF);
    run(3'd0, 20'h2_8000, 16'h0000);
    cmp(q, 32'h0000_FFFF);
    run(3'd0, 20'h3_0000, 16'h0000);
    cmp(q, 32'h0000_5A5A);
    vpp_ok <= 1'b0;
    run(3'd4, 20'h0_0100, 16'h1111);
    rdy();
    run(3'd2, 20'h0_0000, 16'h0070);
    run(3'd0, 20'h0_0000, 16'h0000);
    cmp(q, 32'h0000_0098);
    run(3'd2, 20'h0_0000, 16'h0050);
    run(3'd0, 20'h0_0000, 16'h0000);
    cmp(q, 32'h0000_0080);
    vpp_ok <= 1'b1;
    bus(1'b1, 8'h00, 32'h0000_0010);
    bus(1'b1, 8'h00, 32'h0000_0011);
    bus(1'b0, 8'h10, 32'h0000_0000);
    cmp(q & 32'h0000_0005, 32'h0000_0004);
    cmp({31'h0000_0000, pd_n}, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0000);
    bus(1'b1, 8'h10, 32'h0000_0004);
    run(3'd0, 20'h0_0055, 16'h0000);
    cmp(q, {16'h0000, 16'h0055 ^ 16'h5A5A});
    results();
  end
endmodule
`default_nettype wire
